/* bench/asp_host.sv */
// host model: strobes the port and shifts bits on the serial data line
`timescale 1ns/1ps
module asp_host (
  input  wire logic        clk_sys,
  input  wire logic        sck,
  input  wire logic        sdo,
  input  wire logic        sdo_oe_n,
  output logic             sel,
  output logic             rfs_n,
  output logic             tfs_n,
  output logic             sdi,
  output logic             rx_v,
  output logic [23:0]      rx_d,
  output logic             err
);
  logic sck_p = 1'b0;
  logic drv   = 1'b0;
  logic hd    = 1'b0;
  logic last  = 1'b0;
  initial
  begin
    sel   = 1'b0;
    rfs_n = 1'b1;
    tfs_n = 1'b1;
    rx_v  = 1'b0;
    rx_d  = 24'h000000;
    err   = 1'b0;
  end
  // released data line shows the inverse of its last level
  assign sdi = !sdo_oe_n ? sdo : (drv ? hd : ~last);
  always @(posedge clk_sys)
  begin
    sck_p <= sck;
    if (!sdo_oe_n || drv)
      last <= sdi; // remember only a driven level
  end
  // wait for a serial clock edge, bounded
  task automatic edge_w(input logic r);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (!(sck == r && sck_p != r) && n < 200);
    if (n >= 200) err <= 1'b1;
  endtask
  // read n bits whatever the ready flag does; n = 0 only pulses the strobe
  task automatic rd(input logic s, input int n);
    logic [23:0] w;
    w = 24'h000000;
    @(posedge clk_sys);
    sel   <= s;
    rfs_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      edge_w(1'b1);
      w = {w[22:0], sdi};
    end
    if (n > 0) edge_w(1'b0);
    else repeat (40) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    rfs_n <= 1'b1;
    rx_d  <= w;
    rx_v  <= (n > 0);
    @(posedge clk_sys);
    rx_v  <= 1'b0;
  endtask
  // write 24 bits, MSB set with the strobe, the rest each after a fall, valid at the next rise
  task automatic wr(input logic s, input logic [23:0] w);
    @(posedge clk_sys);
    sel   <= s;
    tfs_n <= 1'b0;
    drv   <= 1'b1;
    hd    <= w[23];
    for (int i = 22; i >= -1; i--)
    begin
      edge_w(1'b1);
      edge_w(1'b0);
      if (i >= 0) hd <= w[i];
    end
    repeat (4) @(posedge clk_sys);
    drv   <= 1'b0;
    tfs_n <= 1'b1;
  endtask
endmodule

/* bench/tb_asp_serial_port.sv */
// self-checking bench of the converter serial port in self-clocking mode, then one external-clock read
`timescale 1ns/1ps
module tb_asp_serial_port;
  import asp_pkg::*;
  typedef struct {string nm; logic [23:0] v;} asp_exp_s;
  logic              clk_sys    = 1'b0;
  logic              resetn     = 1'b0;
  logic              conv_valid = 1'b0;
  logic [23:0]       conv_data  = 24'h000000;
  logic [ADDR_W-1:0] reg_addr   = 4'h0;
  logic [23:0]       reg_wdata  = 24'h000000;
  logic              reg_wr     = 1'b0;
  logic              reg_rd     = 1'b0;
  logic              rd_q       = 1'b0;
  logic              mode       = 1'b1;
  logic              ext_sck    = 1'b0;
  wire logic         sclk_o, sclk_oe_n, sdo, sdo_oe_n, rdy_n, sdi;
  wire logic         sel, rfs_n, tfs_n, rx_v, err;
  wire logic [23:0]  rx_d, reg_rdata;
  int                bad_count  = 0;
  int                cmp_count  = 0;
  int                seed       = 4668;
  logic [23:0]       w, d1, d2, d3;
  asp_exp_s          e;
  asp_exp_s          exp_q[$];
  // serial clock line: device drive, else host clock, low when idle
  wire logic sck = sclk_oe_n ? ext_sck : sclk_o;
  always #5 clk_sys = ~clk_sys;
  asp_serial_port dut (
    .clk_sys(clk_sys), .resetn(resetn), .mode_self(mode),
    .register_select(sel), .read_frame_strobe_n(rfs_n),
    .write_frame_strobe_n(tfs_n), .sclk_i(sck), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .serial_data_line_i(sdi),
    .serial_data_line_o(sdo), .serial_data_line_oe_n(sdo_oe_n),
    .conversion_ready_n(rdy_n), .conv_valid(conv_valid),
    .conv_data(conv_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  asp_host host (
    .clk_sys(clk_sys), .sck(sck), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .sel(sel), .rfs_n(rfs_n), .tfs_n(tfs_n), .sdi(sdi), .rx_v(rx_v),
    .rx_d(rx_d), .err(err));
  task automatic check(input string nm, input logic [23:0] s,
                       input logic [23:0] x);
    cmp_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  // oldest note against each result that shows up
  always @(posedge clk_sys)
  begin
    rd_q <= reg_rd;
    if (rx_v || rd_q)
    begin
      e = exp_q.pop_front();
      check(e.nm, rx_v ? rx_d : reg_rdata, e.v);
    end
  end
  task automatic rw(input logic [ADDR_W-1:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rr(input logic [ADDR_W-1:0] a, input string nm,
                    input logic [23:0] x);
    exp_q.push_back('{nm, x});
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(posedge clk_sys);
  endtask
  // serial read, then both pins must be released
  task automatic srd(input logic s, input int n, input string nm,
                     input logic [23:0] x);
    if (n > 0) exp_q.push_back('{nm, x});
    host.rd(s, n);
    check("sclk_oe_n", sclk_oe_n, 1'b1);
    check("data_oe_n", sdo_oe_n, 1'b1);
  endtask
  task automatic swr(input logic s, input logic [23:0] x);
    host.wr(s, x);
    check("sclk_oe_n", sclk_oe_n, 1'b1);
  endtask
  task automatic conv(input logic [23:0] d);
    @(posedge clk_sys);
    conv_data  <= d;
    conv_valid <= 1'b1;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // cuts a hang short
  initial
  begin
    #500000;
    bad_count++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("rdy", rdy_n, 1'b1);
    rr(ADDR_CTRL, "ctrl", CTRL_RST);
    rr(4'h2, "unmapped", 24'h000000);
    w = (24'($random(seed)) & 24'hFFFFF8) | 24'h000001;
    d1 = 24'($random(seed));
    d2 = 24'($random(seed));
    d3 = 24'($random(seed));
    swr(1'b0, w);
    rr(ADDR_CTRL, "ctrl_wr", w);
    check("rdy", rdy_n, 1'b1);
    srd(1'b0, 24, "ctrl_ser", w);
    check("rdy", rdy_n, 1'b1);
    srd(1'b1, 0, "", 24'h000000);
    conv(d1);
    check("rdy", rdy_n, 1'b0);
    conv(d2);
    check("rdy", rdy_n, 1'b0);
    fork
      srd(1'b1, 24, "out24", d2);
      begin
        repeat (100) @(posedge clk_sys);
        conv(d3);
      end
    join
    check("rdy", rdy_n, 1'b1);
    rw(ADDR_CTRL, w & 24'hFFFFFE);
    conv(d1);
    srd(1'b1, 16, "out16", {8'h00, d1[23:8]});
    check("rdy", rdy_n, 1'b1);
    rw(ADDR_CTRL, w | 24'h000002);
    conv(d2);
    swr(1'b1, d3);
    check("rdy", rdy_n, 1'b0);
    srd(1'b1, 24, "cal_ofs_ser", d3);
    check("rdy", rdy_n, 1'b0);
    rr(ADDR_CAL_OFS, "cal_ofs", d3);
    rw(ADDR_CAL_GAIN, d1);
    rw(ADDR_CTRL, w | 24'h000006);
    srd(1'b1, 24, "cal_gain_ser", d1);
    srd(1'b0, 24, "ctrl_ser2", w | 24'h000006);
    rr(ADDR_STATUS, "status", 24'h000001);
    // external clocking: host supplies the serial clock
    mode <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rr(ADDR_STATUS, "status_ext", 24'h000000);
    fork
      srd(1'b0, 24, "ctrl_ext", w | 24'h000006);
      repeat (24)
      begin
        repeat (8) @(posedge clk_sys);
        ext_sck <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ext_sck <= 1'b0;
      end
    join
    check("host", err, 1'b0);
    end_sim();
  end
endmodule

/* rtl/asp_clkdiv.sv */
// half-period tick generator for the self-generated serial clock
`timescale 1ns/1ps
module asp_clkdiv (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick
);
  import asp_pkg::*;

  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(SCLK_HALF_CYC - 1);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } asp_div_s;

  asp_div_s r_q;
  asp_div_s r_d;

  // count half periods while a transfer runs, restart when idle
  always_comb
  begin
    r_d = r_q;
    if (!run || r_q.cnt == HALF_LAST)
      r_d.cnt = '0;
    else
      r_d.cnt = r_q.cnt + DIV_W'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign tick = run && (r_q.cnt == HALF_LAST);
endmodule

/* rtl/asp_pkg.sv */
// shared constants and types of the converter serial port
package asp_pkg;
  // system clock and self-clocked serial clock timing
  localparam int unsigned SYS_CLK_MHZ   = 100;
  localparam int unsigned SCLK_HALF_NS  = 80;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ) / 1000;
  localparam int unsigned DIV_W         = 8;

  // word and counter widths
  localparam int unsigned WORD_W = 24;
  localparam int unsigned CNT_W  = 5;
  localparam logic [CNT_W-1:0] LEN_24 = 5'h18;
  localparam logic [CNT_W-1:0] LEN_16 = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  // local register port map
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CAL_OFS  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CAL_GAIN = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'hC;

  // control register fields and reset values
  localparam int unsigned CTRL_WL24_BIT  = 0; // 1: 24-bit output word
  localparam int unsigned CTRL_RDCAL_BIT = 1; // 1: select high reads cal
  localparam int unsigned CTRL_CALIX_BIT = 2; // 0: offset, 1: gain
  localparam logic [WORD_W-1:0] CTRL_RST = 24'h000000;
  localparam logic [WORD_W-1:0] CAL_RST  = 24'h000000;

  // status register fields
  localparam int unsigned STAT_MODE_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_CONVERSION_READY_N_BIT = 2;

  // pin synchroniser layout and idle levels
  localparam int unsigned PIN_W    = 6;
  localparam int unsigned PIN_MODE = 0;
  localparam int unsigned PIN_SEL  = 1;
  localparam int unsigned PIN_RFS  = 2;
  localparam int unsigned PIN_TFS  = 3;
  localparam int unsigned PIN_SCK  = 4;
  localparam int unsigned PIN_SDI  = 5;
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h2F; // serial clock idles low

  // transfer state machine
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD,
    ST_WR
  } asp_state_e;

  // all state of the serial port
  typedef struct packed {
    asp_state_e        st;
    logic              sclk;
    logic              drive;
    logic              sdo;
    logic              sel;
    logic              out_rd;
    logic [CNT_W-1:0]  cnt;
    logic [WORD_W-1:0] sh;
    logic [WORD_W-1:0] outw;
    logic              conversion_ready_n_n;
    logic [WORD_W-1:0] ctrl;
    logic [WORD_W-1:0] cal_ofs;
    logic [WORD_W-1:0] cal_gain;
    logic [WORD_W-1:0] rdata;
    logic              rfs_prev;
    logic              tfs_prev;
    logic              sck_prev;
  } asp_regs_s;
endpackage

/* rtl/asp_serial_port.sv */
// serial port of the converter: self-clocked or externally clocked
// How it works
// - mode pin high: device generates serial clock for reads and writes.
// - mode pin low: serial clock pin is an input from host.
// - read with select low returns control; high returns output or cal.
// - new conversion word in output register pulls ready flag low.
// - ready flag returns high after last output bit, 16th or 24th.
// - unread output keeps updating, flag stays low, read gives newest.
// - conversion arriving during output read is dropped, not flagged.
// - control or cal reads leave ready flag alone, run at any level.
// - output read only with flag low; otherwise strobe starts nothing.
// - self mode read strobe fall starts clock, puts MSB on data.
// - self mode read bits change on falling edge, stable at rising.
// - last falling edge gives LSB; next falling edge releases pins.
// - writes ignore the ready flag and never change it.
// - write loads control or calibration per register select level.
// - self mode write strobe fall enables generated serial clock.
// - write bits captured MSB first on rising edges.
// - after falling edge past last write bit, clock output released.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module asp_serial_port (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  // pins
  input  wire logic                        mode_self,
  input  wire logic                        register_select,
  input  wire logic                        read_frame_strobe_n,
  input  wire logic                        write_frame_strobe_n,
  input  wire logic                        sclk_i,
  output logic                             sclk_o,
  output logic                             sclk_oe_n,
  input  wire logic                        serial_data_line_i,
  output logic                             serial_data_line_o,
  output logic                             serial_data_line_oe_n,
  output logic                             conversion_ready_n,
  // converter core
  input  wire logic                        conv_valid,
  input  wire logic [asp_pkg::WORD_W-1:0]  conv_data,
  // local register port
  input  wire logic [asp_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [asp_pkg::WORD_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [asp_pkg::WORD_W-1:0]  reg_rdata
);
  import asp_pkg::*;

  logic             rst_n;
  logic [PIN_W-1:0] pin;
  logic             tick;
  asp_regs_s        r_q;
  asp_regs_s        r_d;

  // reset release and pin synchronisers
  asp_sync #(.W(1), .RST_VAL(1'b0)) u_rst (
    .clk_sys (clk_sys),
    .rst_n   (resetn),
    .d       (1'b1),
    .q       (rst_n)
  );

  asp_sync #(.W(PIN_W), .RST_VAL(PIN_IDLE)) u_pins (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({serial_data_line_i, sclk_i, write_frame_strobe_n,
               read_frame_strobe_n, register_select, mode_self}),
    .q       (pin)
  );

  // self clock half periods only while a self-clocked transfer runs
  asp_clkdiv u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (r_q.drive),
    .tick    (tick)
  );

  // decoded events on synchronised pins
  logic             mode;
  logic             rfs_fall;
  logic             tfs_fall;
  logic             rise_ev;
  logic             fall_ev;
  logic             rd_out;
  logic             rd_ok;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] wr_word;
  logic             rd_done;
  logic             wr_commit;

  always_comb
  begin
    mode     = pin[PIN_MODE];
    rfs_fall = r_q.rfs_prev && !pin[PIN_RFS];
    tfs_fall = r_q.tfs_prev && !pin[PIN_TFS];
    // self mode edges come from the divider, else from the host clock
    if (r_q.drive)
    begin
      rise_ev = tick && !r_q.sclk;
      fall_ev = tick && r_q.sclk;
    end
    else
    begin
      rise_ev = !r_q.sck_prev && pin[PIN_SCK] &&
                !(r_q.st == ST_RD ? pin[PIN_RFS] : pin[PIN_TFS]);
      fall_ev = r_q.sck_prev && !pin[PIN_SCK] &&
                !(r_q.st == ST_RD ? pin[PIN_RFS] : pin[PIN_TFS]);
    end
    rd_out = pin[PIN_SEL] && !r_q.ctrl[CTRL_RDCAL_BIT];
    rd_ok  = !rd_out || !r_q.conversion_ready_n_n;
    // word to send by select level
    if (!pin[PIN_SEL])
      rd_word = r_q.ctrl;
    else if (r_q.ctrl[CTRL_RDCAL_BIT])
      rd_word = r_q.ctrl[CTRL_CALIX_BIT] ? r_q.cal_gain : r_q.cal_ofs;
    else
      rd_word = r_q.outw;
    wr_word   = {r_q.sh[WORD_W-2:0], pin[PIN_SDI]};
    rd_done   = r_q.st == ST_RD && fall_ev && r_q.cnt == CNT_ZERO;
    wr_commit = r_q.st == ST_WR && rise_ev && r_q.cnt == CNT_ONE;
  end

  // next state of the whole port
  always_comb
  begin
    r_d          = r_q;
    r_d.rfs_prev = pin[PIN_RFS];
    r_d.tfs_prev = pin[PIN_TFS];
    r_d.sck_prev = pin[PIN_SCK];

    // conversion results; dropped while output word shifts out
    if (conv_valid && !(r_q.st == ST_RD && r_q.out_rd))
    begin
      r_d.outw   = conv_data;
      r_d.conversion_ready_n_n = 1'b0;
    end

    // local register port, answer one cycle later
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_CTRL:     r_d.ctrl     = reg_wdata;
        ADDR_CAL_OFS:  r_d.cal_ofs  = reg_wdata;
        ADDR_CAL_GAIN: r_d.cal_gain = reg_wdata;
        default:       ;
      endcase
    end
    r_d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CTRL:     r_d.rdata = r_q.ctrl;
        ADDR_CAL_OFS:  r_d.rdata = r_q.cal_ofs;
        ADDR_CAL_GAIN: r_d.rdata = r_q.cal_gain;
        ADDR_STATUS:
        begin
          r_d.rdata[STAT_MODE_BIT] = mode;
          r_d.rdata[STAT_BUSY_BIT] = r_q.st != ST_IDLE;
          r_d.rdata[STAT_CONVERSION_READY_N_BIT] = r_q.conversion_ready_n_n;
        end
        default:       r_d.rdata = '0;
      endcase
    end

    unique case (r_q.st)
      ST_IDLE:
      begin
        if (rfs_fall && rd_ok)
        begin
          // start read: MSB out at once, clock held low
          r_d.st     = ST_RD;
          r_d.sel    = pin[PIN_SEL];
          r_d.out_rd = rd_out;
          r_d.cnt    = (rd_out && !r_q.ctrl[CTRL_WL24_BIT]) ? LEN_16
                                                             : LEN_24;
          r_d.sdo    = rd_word[WORD_W-1];
          r_d.sh     = {rd_word[WORD_W-2:0], 1'b0};
          r_d.sclk   = 1'b0;
          r_d.drive  = mode;
        end
        else if (tfs_fall)
        begin
          r_d.st    = ST_WR;
          r_d.sel   = pin[PIN_SEL];
          r_d.cnt   = LEN_24;
          r_d.sclk  = 1'b0;
          r_d.drive = mode;
        end
      end
      ST_RD:
      begin
        if (rise_ev)
        begin
          r_d.sclk = 1'b1;
          r_d.cnt  = r_q.cnt - CNT_ONE;
        end
        else if (fall_ev)
        begin
          r_d.sclk = 1'b0;
          if (r_q.cnt == CNT_ZERO)
          begin
            // release pins; output read re-arms the flag
            r_d.st    = ST_IDLE;
            r_d.drive = 1'b0;
            if (r_q.out_rd)
              r_d.conversion_ready_n_n = 1'b1;
          end
          else
          begin
            r_d.sdo = r_q.sh[WORD_W-1];
            r_d.sh  = {r_q.sh[WORD_W-2:0], 1'b0};
          end
        end
      end
      ST_WR:
      begin
        if (rise_ev)
        begin
          r_d.sclk = 1'b1;
          r_d.sh   = wr_word;
          r_d.cnt  = r_q.cnt - CNT_ONE;
          if (wr_commit)
          begin
            if (!r_q.sel)
              r_d.ctrl = wr_word;
            else if (r_q.ctrl[CTRL_CALIX_BIT])
              r_d.cal_gain = wr_word;
            else
              r_d.cal_ofs = wr_word;
          end
        end
        else if (fall_ev)
        begin
          r_d.sclk = 1'b0;
          if (r_q.cnt == CNT_ZERO)
          begin
            r_d.st    = ST_IDLE;
            r_d.drive = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q          <= '0;
      r_q.st       <= ST_IDLE;
      r_q.conversion_ready_n_n   <= 1'b1;
      r_q.ctrl     <= CTRL_RST;
      r_q.cal_ofs  <= CAL_RST;
      r_q.cal_gain <= CAL_RST;
      r_q.rfs_prev <= 1'b1;
      r_q.tfs_prev <= 1'b1;
      r_q.sck_prev <= 1'b0;
    end
    else
      r_q <= r_d;
  end

  // pin drivers: enables low while driving
  assign sclk_o                = r_q.sclk;
  assign sclk_oe_n             = !r_q.drive;
  assign serial_data_line_o    = r_q.sdo;
  assign serial_data_line_oe_n = !(r_q.st == ST_RD &&
                                   (r_q.drive || !pin[PIN_RFS]));
  assign conversion_ready_n    = r_q.conversion_ready_n_n;
  assign reg_rdata             = r_q.rdata;

  // checks on the transfer logic
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_start;
    r_q.st == ST_IDLE && !(rfs_fall && rd_ok) && tfs_fall && mode;
  endsequence

  sequence s_rd_start;
    r_q.st == ST_IDLE && rfs_fall && rd_ok && mode;
  endsequence

  idle_release_a: assert property (
    r_q.st == ST_IDLE |-> sclk_oe_n && serial_data_line_oe_n)
    else $error("pins driven while idle");

  ext_clock_in_a: assert property (
    (r_q.st == ST_IDLE && !mode) ##1 r_q.st != ST_IDLE |-> sclk_oe_n)
    else $error("clock driven in external mode");

  rd_start_a: assert property (
    s_rd_start |=> !sclk_oe_n && !serial_data_line_oe_n &&
      serial_data_line_o == $past(rd_word[WORD_W-1]))
    else $error("read start did not present MSB");

  wr_clock_a: assert property (
    s_wr_start |=> r_q.st == ST_WR && !sclk_oe_n && !sclk_o)
    else $error("write start did not enable clock");

  read_refuse_a: assert property (
    r_q.st == ST_IDLE && rfs_fall && rd_out && r_q.conversion_ready_n_n && !tfs_fall
    |=> r_q.st == ST_IDLE)
    else $error("output read started with flag high");

  ready_low_a: assert property (
    conv_valid && !(r_q.st == ST_RD && r_q.out_rd) && !rd_done
    |=> !conversion_ready_n && r_q.outw == $past(conv_data))
    else $error("new word not flagged");

  conv_drop_a: assert property (
    conv_valid && r_q.st == ST_RD && r_q.out_rd |=> $stable(r_q.outw))
    else $error("word replaced during output read");

  ready_high_a: assert property (
    rd_done && r_q.out_rd |=> conversion_ready_n && sclk_oe_n)
    else $error("flag not raised after last bit");

  flag_hold_a: assert property (
    (r_q.st == ST_WR || (r_q.st == ST_RD && !r_q.out_rd)) &&
    !conversion_ready_n |=> !conversion_ready_n)
    else $error("flag changed by register access");

  bit_stable_a: assert property (
    r_q.st == ST_RD && rise_ev |=> $stable(serial_data_line_o))
    else $error("data changed on rising edge");

  wr_load_a: assert property (
    wr_commit && !r_q.sel |=> r_q.ctrl == $past(wr_word))
    else $error("control not loaded by write");
endmodule

/* rtl/asp_sync.sv */
// two-flop synchroniser with a constant reset value
`timescale 1ns/1ps
module asp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } asp_sync_s;

  asp_sync_s r_q;
  asp_sync_s r_d;

  // first stage feeds only the second
  always_comb
  begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= {RST_VAL, RST_VAL};
    else
      r_q <= r_d;
  end

  assign q = r_q.s2;
endmodule
